// *** logic/fem_top.sv ***
// FIR event monitor, coefficient reload, multiply-accumulate datapath, APB.
// Assumes AXI4-Stream sources synchronous to pclk; output is never stalled.
`timescale 1ns/1ps
`default_nettype none
`include "fem_params.svh"
module fem_top
  import fem_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample stream in
  input wire logic s_data_tvalid,
  output logic s_data_tready,
  input wire logic [`FEM_DW-1:0] s_data_tdata,
  input wire logic s_data_tlast,
  input wire logic [7:0] s_data_tuser,
  // Config stream in
  input wire logic s_cfg_tvalid,
  output logic s_cfg_tready,
  input wire logic [7:0] s_cfg_tdata,
  input wire logic s_cfg_tlast,
  // Reload stream in
  input wire logic s_rld_tvalid,
  output logic s_rld_tready,
  input wire logic [`FEM_CW-1:0] s_rld_tdata,
  input wire logic s_rld_tlast,
  // Filtered output
  output logic m_data_tvalid,
  output logic [`FEM_OW-1:0] m_data_tdata,
  // Events
  output logic ev_data_last_missing,
  output logic ev_data_last_unexpected,
  output logic ev_data_chan_wrong,
  output logic ev_cfg_last_missing,
  output logic ev_cfg_last_unexpected,
  output logic ev_rld_last_missing,
  output logic ev_rld_last_unexpected
);

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [4:0] mult_count(input logic [31:0] c);
    logic [4:0] need;
    logic [3:0] cyc;
    need = (c[`FEM_B_SYM_LO+:2] != `FEM_SYM_NONE && !c[`FEM_B_TRANSPOSE])
           ? 5'(`FEM_HALF) : 5'(`FEM_TAPS);
    cyc = (c[`FEM_B_CPS_LO+:4] == 4'h0) ? 4'h1 : c[`FEM_B_CPS_LO+:4];
    mult_count = 5'((need + 5'(cyc) - 5'h1) / 5'(cyc));
  endfunction : mult_count

  function automatic logic [`FEM_OW-1:0] mul_acc(input fem_coef_t k,
      input logic [`FEM_TAPS-1:0][`FEM_DW-1:0] h, input logic [31:0] c);
    logic signed [`FEM_OW-1:0] acc;
    logic signed [`FEM_DW:0] pre;
    logic fold;
    acc = '0;
    pre = '0;
    // Transposed form never folds; latency wins over multipliers
    fold = c[`FEM_B_SYM_LO+:2] != `FEM_SYM_NONE && !c[`FEM_B_TRANSPOSE];
    for (int i = 0; i < `FEM_TAPS; i++) begin
      if (!fold) begin
        pre = $signed({h[i][`FEM_DW-1], h[i]});
        acc = acc + `FEM_OW'($signed(k[i]) * pre);
      end else if (i < `FEM_HALF) begin
        if (c[`FEM_B_SYM_LO+:2] == `FEM_SYM_NEG) begin
          pre = $signed({h[i][`FEM_DW-1], h[i]}) -
                $signed({h[`FEM_TAPS-1-i][`FEM_DW-1], h[`FEM_TAPS-1-i]});
        end else begin
          pre = $signed({h[i][`FEM_DW-1], h[i]}) +
                $signed({h[`FEM_TAPS-1-i][`FEM_DW-1], h[`FEM_TAPS-1-i]});
        end
        acc = acc + `FEM_OW'($signed(k[i]) * pre);
      end
    end
    mul_acc = acc;
  endfunction : mul_acc

  // ************************************
  // State
  // ************************************
  fem_state_t s_reg, s_next;
  fem_keep_t k_reg, k_next;
  logic [4:0] mults;
  logic [5:0] pad;
  logic d_go, c_go, r_go, c_end, r_end, sync, last_ch, flush;
  logic [1:0] tlm;

  assign mults = mult_count(s_reg.ctrl);
  // Spare multiply slots become zero coefficients; they are only counted
  // in the MULT register and do not delay the impulse response
  assign pad = 6'(mults * s_reg.ctrl[`FEM_B_CPS_LO+:4]) -
               ((s_reg.ctrl[`FEM_B_SYM_LO+:2] != `FEM_SYM_NONE &&
                 !s_reg.ctrl[`FEM_B_TRANSPOSE]) ? 6'(`FEM_HALF)
                : 6'(`FEM_TAPS));

  assign d_go = s_data_tvalid && s_reg.data_rdy;
  assign c_go = s_cfg_tvalid && s_reg.cfg_rdy;
  assign r_go = s_rld_tvalid && k_reg.rld_rdy;
  assign tlm = s_reg.ctrl[`FEM_B_TL_LO+:2];
  assign last_ch = s_reg.exp_chan == 1'(`FEM_CHANS - 1);
  assign c_end = s_reg.cfg_cnt == 1'(`FEM_CFG_LEN - 1);
  assign r_end = s_reg.rld_cnt == 3'(`FEM_TAPS - 1);
  assign sync = c_go && c_end;
  assign flush = psel && penable && pwrite && !s_reg.pready &&
                 paddr == `FEM_ADDR_CTRL && pwdata[`FEM_B_FLUSH];

  // ************************************
  // Next state
  // ************************************
  always_comb begin
    s_next = s_reg;
    k_next = k_reg;
    s_next.ev_data = '0;
    s_next.ev_cfg = '0;
    s_next.ev_rld = '0;
    s_next.pslverr = 1'b0;
    s_next.pready = psel && penable && !s_reg.pready;
    if (psel && penable && !s_reg.pready) begin
      s_next.prdata = '0;
      unique case (paddr)
        `FEM_ADDR_CTRL: begin
          if (pwrite) begin
            s_next.ctrl = pwdata & `FEM_CTRL_MASK;
          end else begin
            s_next.prdata = s_reg.ctrl;
          end
        end
        `FEM_ADDR_STAT: s_next.prdata = {16'h0, s_reg.syncs, 1'b0,
                                         s_reg.rld_cnt, s_reg.exp_chan,
                                         s_reg.cfg_cnt, k_reg.pend_full,
                                         k_reg.rld_rdy};
        `FEM_ADDR_MULT: s_next.prdata = {18'h0, pad, 3'h0, mults};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // Sample stream
    s_next.data_rdy = 1'b1;
    s_next.sys_vld = 1'b0;
    s_next.out_vld = 1'b0;
    if (d_go) begin
      s_next.hist[s_reg.exp_chan] = {s_reg.hist[s_reg.exp_chan]
                                     [`FEM_TAPS-2:0], s_data_tdata};
      s_next.exp_chan = last_ch ? 1'b0 : 1'b1;
      if (tlm == `FEM_TL_VEC && last_ch && !s_data_tlast) begin
        s_next.ev_data[0] = 1'b1;
      end
      if (s_data_tlast && !last_ch && (tlm == `FEM_TL_VEC ||
          (tlm == `FEM_TL_PKT && s_reg.ctrl[`FEM_B_DOWN]))) begin
        s_next.ev_data[1] = 1'b1;
      end
      if (s_reg.ctrl[`FEM_B_CHANID] &&
          s_data_tuser != 8'(s_reg.exp_chan)) begin
        s_next.ev_data[2] = 1'b1;
      end
      if (s_reg.ctrl[`FEM_B_TRANSPOSE]) begin
        s_next.out_vld = 1'b1;
        s_next.out_data = mul_acc(k_reg.active,
                              s_next.hist[s_reg.exp_chan], s_reg.ctrl);
      end else begin
        s_next.sys_vld = 1'b1;
        s_next.sys_sum = mul_acc(k_reg.active,
                             s_next.hist[s_reg.exp_chan], s_reg.ctrl);
      end
    end
    // Systolic form adds a pipeline stage before the output
    if (s_reg.sys_vld) begin
      s_next.out_vld = 1'b1;
      s_next.out_data = s_reg.sys_sum;
    end
    // Config stream
    s_next.cfg_rdy = s_reg.ctrl[`FEM_B_CFG_EN];
    if (c_go) begin
      s_next.cfg_cnt = c_end ? 1'b0 : 1'b1;
      s_next.ev_cfg[0] = c_end && !s_cfg_tlast;
      s_next.ev_cfg[1] = !c_end && s_cfg_tlast;
      s_next.cfg_rdy = 1'b1;
    end
    if (sync) begin
      s_next.syncs = s_reg.syncs + 8'h1;
    end
    // Reload stream
    if (r_go) begin
      k_next.pend[s_reg.rld_cnt] = s_rld_tdata;
      if (r_end) begin
        s_next.rld_cnt = 3'h0;
        k_next.pend_full = 1'b1;
        s_next.ev_rld[0] = !s_rld_tlast;
      end else if (s_rld_tlast) begin
        s_next.rld_cnt = 3'h0;
        s_next.ev_rld[1] = 1'b1;
      end else begin
        s_next.rld_cnt = s_reg.rld_cnt + 3'h1;
      end
    end
    // A set completing in the same cycle stays pending: set wins
    if (sync && k_reg.pend_full) begin
      k_next.active = k_reg.pend;
      k_next.pend_full = r_go && r_end;
    end
    if (flush) begin
      k_next.pend_full = r_go && r_end;
      k_next.active = '0;
    end
    k_next.rld_rdy = s_reg.ctrl[`FEM_B_RLD_EN] &&
                     (s_reg.ctrl[`FEM_B_MULTI] || !k_next.pend_full);
    // Disabled sample missing-last, config and reload events are masked here
    if (tlm != `FEM_TL_VEC) s_next.ev_data[0] = 1'b0;
    if (!s_reg.ctrl[`FEM_B_CFG_EN]) s_next.ev_cfg = '0;
    if (!s_reg.ctrl[`FEM_B_RLD_EN]) s_next.ev_rld = '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= `FEM_CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Coefficients are kept across reset on purpose; flush via CTRL
  always_ff @(posedge pclk) begin
    k_reg <= k_next;
  end

  // ************************************
  // Outputs
  // ************************************
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign s_data_tready = s_reg.data_rdy;
  assign s_cfg_tready = s_reg.cfg_rdy;
  assign s_rld_tready = k_reg.rld_rdy;
  assign m_data_tvalid = s_reg.out_vld;
  assign m_data_tdata = s_reg.out_data;
  assign ev_data_last_missing = s_reg.ev_data[0];
  assign ev_data_last_unexpected = s_reg.ev_data[1];
  assign ev_data_chan_wrong = s_reg.ev_data[2];
  assign ev_cfg_last_missing = s_reg.ev_cfg[0];
  assign ev_cfg_last_unexpected = s_reg.ev_cfg[1];
  assign ev_rld_last_missing = s_reg.ev_rld[0];
  assign ev_rld_last_unexpected = s_reg.ev_rld[1];

  // ************************************
  // Checks
  // ************************************
  sequence s_rld_full_end;
    r_go && r_end;
  endsequence

  property p_rld_pulse;
    @(posedge pclk) disable iff (!presetn)
    ev_rld_last_missing |=> !ev_rld_last_missing;
  endproperty
  a_rld_pulse: assert property (p_rld_pulse)
    else $error("reload missing-last longer than one cycle");

  property p_data_missing;
    @(posedge pclk) disable iff (!presetn)
    d_go && tlm == `FEM_TL_VEC && last_ch && !s_data_tlast
      |=> ev_data_last_missing;
  endproperty
  a_data_missing: assert property (p_data_missing)
    else $error("missing sample tlast not flagged");

  property p_data_unexp;
    @(posedge pclk) disable iff (!presetn)
    d_go && s_data_tlast && !last_ch && tlm == `FEM_TL_VEC
      |=> ev_data_last_unexpected;
  endproperty
  a_data_unexp: assert property (p_data_unexp)
    else $error("unexpected sample tlast not flagged");

  property p_chan;
    @(posedge pclk) disable iff (!presetn)
    ev_data_chan_wrong |-> $past(s_reg.ctrl[`FEM_B_CHANID]) && $past(d_go);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel event without enabled transfer");

  property p_cfg_unexp;
    @(posedge pclk) disable iff (!presetn)
    c_go && !c_end && s_cfg_tlast |=> ev_cfg_last_unexpected;
  endproperty
  a_cfg_unexp: assert property (p_cfg_unexp)
    else $error("unexpected config tlast not flagged");

  property p_single_slot;
    @(posedge pclk) disable iff (!presetn)
    s_rld_full_end ##0 !s_reg.ctrl[`FEM_B_MULTI] ##0 !sync
      |=> !s_rld_tready;
  endproperty
  a_single_slot: assert property (p_single_slot)
    else $error("reload ready high with single slot full");

  property p_commit;
    @(posedge pclk) disable iff (!presetn)
    sync && k_reg.pend_full && !flush |=> k_reg.active == $past(k_reg.pend);
  endproperty
  a_commit: assert property (p_commit)
    else $error("pending set not committed on config packet");

  property p_transpose_lat;
    @(posedge pclk) disable iff (!presetn)
    d_go && s_reg.ctrl[`FEM_B_TRANSPOSE] |=> m_data_tvalid;
  endproperty
  a_transpose_lat: assert property (p_transpose_lat)
    else $error("transposed output not one cycle after sample");

  property p_cfg_off;
    @(posedge pclk) disable iff (!presetn)
    !s_reg.ctrl[`FEM_B_CFG_EN]
      |=> !ev_cfg_last_missing && !ev_cfg_last_unexpected;
  endproperty
  a_cfg_off: assert property (p_cfg_off)
    else $error("config event while port disabled");

endmodule : fem_top
`default_nettype wire

// *** logic/fem_params.svh ***
// Constants for the FIR event monitor and datapath.
// Assumes byte addressing on a 32-bit APB bus.
`ifndef FEM_PARAMS_SVH
`define FEM_PARAMS_SVH
`define FEM_TAPS 8
`define FEM_HALF 4
`define FEM_CHANS 2
`define FEM_DW 16
`define FEM_CW 16
`define FEM_OW 40
`define FEM_CFG_LEN 2
`define FEM_ADDR_CTRL 12'h000
`define FEM_ADDR_STAT 12'h004
`define FEM_ADDR_MULT 12'h008
`define FEM_CTRL_RST 32'h0000_0400
`define FEM_CTRL_MASK 32'h0000_3fff
`define FEM_B_TRANSPOSE 0
`define FEM_B_SYM_LO 1
`define FEM_B_TL_LO 3
`define FEM_B_DOWN 5
`define FEM_B_CHANID 6
`define FEM_B_CFG_EN 7
`define FEM_B_RLD_EN 8
`define FEM_B_MULTI 9
`define FEM_B_CPS_LO 10
`define FEM_B_FLUSH 16
`define FEM_SYM_NONE 2'h0
`define FEM_SYM_POS 2'h1
`define FEM_SYM_NEG 2'h2
`define FEM_TL_OFF 2'h0
`define FEM_TL_VEC 2'h1
`define FEM_TL_PKT 2'h2
`endif

// *** logic/fem_pkg.sv ***
// Types for the FIR event monitor and datapath.
// Needs fem_params.svh on the include path.
`include "fem_params.svh"
package fem_pkg;
  typedef logic [`FEM_CHANS-1:0][`FEM_TAPS-1:0][`FEM_DW-1:0] fem_hist_t;
  typedef logic [`FEM_TAPS-1:0][`FEM_CW-1:0] fem_coef_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] ctrl;
    logic [2:0] ev_data;
    logic [1:0] ev_cfg;
    logic [1:0] ev_rld;
    logic exp_chan;
    logic [0:0] cfg_cnt;
    logic [2:0] rld_cnt;
    logic data_rdy;
    logic cfg_rdy;
    logic sys_vld;
    logic [`FEM_OW-1:0] sys_sum;
    logic out_vld;
    logic [`FEM_OW-1:0] out_data;
    fem_hist_t hist;
    logic [7:0] syncs;
  } fem_state_t;
  typedef struct packed {
    fem_coef_t active;
    fem_coef_t pend;
    logic pend_full;
    logic rld_rdy;
  } fem_keep_t;
endpackage : fem_pkg

// *** test/fem_src.sv ***
// Upstream stream sources for samples, config and coefficients.
// Assumes one pclk; the bench calls beat() by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module fem_src (
  // Clock
  input wire logic pclk,
  // Sample stream
  output logic d_v,
  output logic [15:0] d_d,
  output logic d_l,
  output logic [7:0] d_u,
  input wire logic d_r,
  // Config stream
  output logic c_v,
  output logic [7:0] c_d,
  output logic c_l,
  input wire logic c_r,
  // Reload stream
  output logic r_v,
  output logic [15:0] r_d,
  output logic r_l,
  input wire logic r_r,
  // Stuck handshake
  output logic hung
);
  initial begin
    {d_v, d_d, d_l, d_u, c_v, c_d, c_l} = '0;
    {r_v, r_d, r_l, hung} = '0;
  end
  // ****************************************
  // One beat, held until ready is sampled
  // ****************************************
  task automatic beat(input int s, input logic [15:0] v, input logic l,
                      input logic [7:0] u);
    int n;
    logic ok;
    n = 0;
    @(posedge pclk);
    case (s)
      0: {d_v, d_d, d_l, d_u} <= {1'b1, v, l, u};
      1: {c_v, c_d, c_l} <= {1'b1, v[7:0], l};
      default: {r_v, r_d, r_l} <= {1'b1, v, l};
    endcase
    do begin
      @(posedge pclk);
      ok = (s == 0) ? d_r : (s == 1) ? c_r : r_r;
      n++;
    end while (ok !== 1'b1 && n < 400);
    if (ok !== 1'b1) hung <= 1'b1;
    // Released lines flip so stale data never looks valid
    case (s)
      0: {d_v, d_d, d_l, d_u} <= {1'b0, ~v, ~l, ~u};
      1: {c_v, c_d, c_l} <= {1'b0, ~v[7:0], ~l};
      default: {r_v, r_d, r_l} <= {1'b0, ~v, ~l};
    endcase
  endtask : beat
endmodule : fem_src
`default_nettype wire

// *** test/fir_event_monitor_and_mac_datapath_bench.sv ***
// Self-checking bench: APB master tasks plus stream beats.
// Assumes fem_top and fem_src; events are checked the cycle after a beat.
`timescale 1ns/1ps
`default_nettype none
`include "fem_params.svh"
module fir_event_monitor_and_mac_datapath_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, m_v, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] m_d;
  logic [6:0] ev;
  logic d_v, d_l, d_r, c_v, c_l, c_r, r_v, r_l, r_r, hung;
  logic [15:0] d_d, r_d;
  logic [7:0] d_u, c_d;
  logic [39:0] outq[$];
  logic dl[6] = '{0, 1, 0, 0, 1, 1};
  logic [7:0] du[6] = '{8'h0, 8'h1, 8'h1, 8'h1, 8'h0, 8'h1};
  logic [6:0] de[6] = '{7'h0, 7'h0, 7'h10, 7'h40, 7'h20, 7'h0};
  logic [31:0] mc[4] = '{32'hc03, 32'hc02, 32'h404, 32'h2000};
  logic [31:0] mm[4] = '{32'h103, 32'h202, 32'h004, 32'h001};
  int n_fail = 0;
  int tests_run = 0;
  fem_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .s_data_tvalid(d_v), .s_data_tready(d_r), .s_data_tdata(d_d),
    .s_data_tlast(d_l), .s_data_tuser(d_u), .s_cfg_tvalid(c_v),
    .s_cfg_tready(c_r), .s_cfg_tdata(c_d), .s_cfg_tlast(c_l),
    .s_rld_tvalid(r_v), .s_rld_tready(r_r), .s_rld_tdata(r_d),
    .s_rld_tlast(r_l), .m_data_tvalid(m_v), .m_data_tdata(m_d),
    .ev_data_last_missing(ev[6]), .ev_data_last_unexpected(ev[5]),
    .ev_data_chan_wrong(ev[4]), .ev_cfg_last_missing(ev[3]),
    .ev_cfg_last_unexpected(ev[2]), .ev_rld_last_missing(ev[1]),
    .ev_rld_last_unexpected(ev[0]));
  fem_src src_u (.pclk(pclk), .d_v(d_v), .d_d(d_d), .d_l(d_l), .d_u(d_u),
    .d_r(d_r), .c_v(c_v), .c_d(c_d), .c_l(c_l), .c_r(c_r), .r_v(r_v),
    .r_d(r_d), .r_l(r_l), .r_r(r_r), .hung(hung));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (m_v === 1'b1) outq.push_back(m_d);
  always @(posedge pclk) if (hung === 1'b1) begin
    n_fail++;
    print_verdict();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [39:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic evb(input int s, input logic [15:0] v, input logic l,
                     input logic [7:0] u, input logic [6:0] e);
    src_u.beat(s, v, l, u);
    #1;
    chk("event pulse", e, ev);
    @(posedge pclk);
    #1;
    chk("event cleared", 7'h0, ev);
  endtask : evb
  // Reload set of 8; lp is the beat that carries tlast, 8 for none
  task automatic rset(input int b, input int lp);
    for (int k = 0; k <= 7 && k <= lp; k++)
      evb(2, 16'(b + k), k == lp, 8'h0, (k == lp && lp < 7) ? 7'h01 :
          (k == 7 && lp > 7) ? 7'h02 : 7'h00);
  endtask : rset
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  // Impulse of 3 on channel 0, wrong tuser and tlast with checks off
  task automatic imp();
    outq.delete();
    for (int k = 0; k < 16; k++)
      evb(0, k == 0 ? 16'h3 : 16'h0, ~k[0], {7'h0, ~k[0]}, 7'h0);
    repeat (4) @(posedge pclk);
    chk("output count", 40'd16, 40'(outq.size()));
    for (int j = 0; j < 8; j++)
      chk("impulse tap", 40'(3 * (30 + j)), outq[2 * j]);
  endtask : imp
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, se} = '0;
    repeat (60000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
  initial begin
    do_reset();
    rdchk(12'h000, 32'h400, "ctrl reset value");
    chk("sample ready", 40'h1, d_r);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped error", 40'h1, se);
    apb(1'b1, 12'h000, 32'h105c9);
    rdchk(12'h000, 32'h5c9, "ctrl readback");
    chk("config ready", 40'h1, c_r);
    foreach (dl[i]) evb(0, 16'h5, dl[i], du[i], de[i]);
    apb(1'b1, 12'h000, 32'h5f1);
    evb(0, 16'h5, 1'b1, 8'h0, 7'h20);
    evb(0, 16'h5, 1'b1, 8'h1, 7'h00);
    rset(1, 8);
    chk("reload ready held", 40'h0, r_r);
    do_reset();
    apb(1'b1, 12'h000, 32'h5c9);
    apb(1'b0, 12'h004, 32'h0);
    chk("pending kept", 40'h1, rd[1]);
    chk("reload blocked", 40'h0, r_r);
    repeat (4) @(posedge pclk);
    evb(1, 16'h0, 1'b0, 8'h0, 7'h0);
    evb(1, 16'h0, 1'b1, 8'h0, 7'h0);
    chk("reload ready after sync", 40'h1, r_r);
    rset(10, 2);
    do_reset();
    apb(1'b1, 12'h000, 32'h5c9);
    rset(20, 7);
    apb(1'b0, 12'h004, 32'h0);
    chk("full set pending", 40'h1, rd[1]);
    evb(1, 16'h0, 1'b0, 8'h0, 7'h0);
    evb(1, 16'h0, 1'b0, 8'h0, 7'h08);
    apb(1'b1, 12'h000, 32'h781);
    rset(40, 7);
    rset(30, 7);
    chk("second slot accepts", 40'h1, r_r);
    repeat (4) @(posedge pclk);
    evb(1, 16'h0, 1'b0, 8'h0, 7'h0);
    evb(1, 16'h0, 1'b1, 8'h0, 7'h0);
    evb(1, 16'h0, 1'b1, 8'h0, 7'h04);
    do_reset();
    apb(1'b1, 12'h000, 32'h781);
    imp();
    apb(1'b1, 12'h000, 32'h780);
    imp();
    foreach (mc[i]) begin
      apb(1'b1, 12'h000, mc[i]);
      rdchk(12'h008, mm[i], "mult and pad");
    end
    print_verdict();
  end
endmodule : fir_event_monitor_and_mac_datapath_bench
`default_nettype wire
